// [shared/clock_switch_pkg.sv]
// Constants, types and helpers shared by the clock switch and fail-safe monitor
// Summary of operation
// - Dead system clock forces fast RC, raises NMI
// - Sleep halts the fail-safe monitor
// - Software may select any of five sources
// - Primary submode fixed by configuration only
// - Switching and monitor enabled only when fuse is 0
// - Disabled: current source follows reset fuse
// - Disabled: switch request ignored, reads zero
// - Equal sources: clear request, abort switch
// - Valid switch clears lock and fail flags
// - Start oscillator, wait startup timer or lock
// - Count ten new-clock cycles before switching
// - Completion clears request, copies new to current
// - Old oscillator off unless kept enabled
// - Processor keeps running during the switch
`default_nettype none
package clock_switch_pkg;

  // Unlock keys, in the order they must arrive
  localparam logic [31:0] UNLOCK_KEY_FIRST  = 32'hAA996655;
  localparam logic [31:0] UNLOCK_KEY_SECOND = 32'h556699AA;

  // Source codes held in the new and current source fields
  localparam logic [2:0] SRC_FAST_RC   = 3'h0;
  localparam logic [2:0] SRC_PLL       = 3'h1;
  localparam logic [2:0] SRC_PRIMARY   = 3'h2;
  localparam logic [2:0] SRC_SECONDARY = 3'h4;
  localparam logic [2:0] SRC_LOW_POWER = 3'h5;

  // Primary submode configuration codes
  localparam logic [1:0] SUBMODE_EXTERNAL = 2'h0;
  localparam logic [1:0] SUBMODE_CRYSTAL  = 2'h1;
  localparam logic [1:0] SUBMODE_HIGH_SPD = 2'h2;

  // Oscillator index within enable, ready and clock-sense vectors
  localparam int NUM_OSC   = 5;
  localparam int OSC_FRC   = 0;
  localparam int OSC_PRIMARY_OSCILLATOR  = 1;
  localparam int OSC_SECONDARY_OSCILLATOR  = 2;
  localparam int OSC_LOW_POWER_RC_OSCILLATOR  = 3;
  localparam int OSC_PLL   = 4;

  // Timing: core clock period, monitor timeout, startup and settle counts
  localparam int CLK_PERIOD_NS    = 100;
  localparam int FAIL_TIMEOUT_NS  = 100000;
  localparam int FAIL_CYCLES      = FAIL_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam logic [10:0] OST_EDGES    = 11'h400;
  localparam logic [10:0] SETTLE_EDGES = 11'h00A;

  // Low half of the oscillator control register
  typedef struct packed {
    logic       rsv15;
    logic [2:0] current_source_status;   // Bits 14:12
    logic       rsv11;
    logic [2:0] new_source_select;       // Bits 10:8
    logic [3:0] rsv7_4;
    logic       clock_fail_flag;         // Bit 3
    logic [1:0] rsv2_1;
    logic       switch_request;          // Bit 0
  } osc_ctrl_t;

  // Static configuration word
  typedef struct packed {
    logic       switch_monitor_enable_fuse;  // 0 enables, 1 disables
    logic [2:0] reset_source_fuse;
    logic [1:0] primary_submode_select;
    logic       pll_from_primary;            // PLL reference: 1 primary, 0 fast RC
  } osc_config_t;

  // Oscillators a source needs running; PLL pulls in its reference
  function automatic logic [NUM_OSC-1:0] src_mask(input logic [2:0] src,
                                                  input logic       pll_prim);
    logic [NUM_OSC-1:0] m;
    m = '0;
    case (src)
      SRC_PLL: begin
        m[OSC_PLL] = 1'b1;
        if (pll_prim) m[OSC_PRIMARY_OSCILLATOR] = 1'b1;
        else          m[OSC_FRC]  = 1'b1;
      end
      SRC_PRIMARY:   m[OSC_PRIMARY_OSCILLATOR] = 1'b1;
      SRC_SECONDARY: m[OSC_SECONDARY_OSCILLATOR] = 1'b1;
      SRC_LOW_POWER: m[OSC_LOW_POWER_RC_OSCILLATOR] = 1'b1;
      default:       m[OSC_FRC]  = 1'b1;
    endcase
    return m;
  endfunction

  // Index of the oscillator whose output is the source's clock
  function automatic int src_index(input logic [2:0] src);
    case (src)
      SRC_PLL:       return OSC_PLL;
      SRC_PRIMARY:   return OSC_PRIMARY_OSCILLATOR;
      SRC_SECONDARY: return OSC_SECONDARY_OSCILLATOR;
      SRC_LOW_POWER: return OSC_LOW_POWER_RC_OSCILLATOR;
      default:       return OSC_FRC;
    endcase
  endfunction

endpackage
`default_nettype wire

// [hdl/clock_switch_failsafe_monitor.sv]
// Clock source switch sequencer with unlock keys and fail-safe clock monitor
`default_nettype none
module clock_switch_failsafe_monitor (
  // Clock and reset
  input  wire logic                                 core_clk,
  input  wire logic                                 srst,
  // Static configuration and power state
  input  wire clock_switch_pkg::osc_config_t        cfg,
  input  wire logic                                 sleep_mode,
  // Software register writes
  input  wire logic                                 key_wr,
  input  wire logic [31:0]                          key_wdata,
  input  wire logic                                 ctrl_wr,
  input  wire clock_switch_pkg::osc_ctrl_t          ctrl_wdata,
  // Oscillator side; ready and clock-sense asynchronous to core_clk
  input  wire logic [clock_switch_pkg::NUM_OSC-1:0] osc_ready,
  input  wire logic [clock_switch_pkg::NUM_OSC-1:0] osc_clk_sense,
  input  wire logic [clock_switch_pkg::NUM_OSC-1:0] osc_keep_on,
  output var  logic [clock_switch_pkg::NUM_OSC-1:0] osc_enable,
  // Status back to software and system
  output var  clock_switch_pkg::osc_ctrl_t          ctrl_rdata,
  output var  logic                                 pll_lock_status,
  output var  logic [2:0]                           system_clock_net_select,
  output var  logic                                 unlocked,
  output logic                                      switch_busy,
  output var  logic                                 fail_nmi
);

  localparam int NV = 2 * clock_switch_pkg::NUM_OSC;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_CHECK  = 5'h02,
    ST_START  = 5'h04,
    ST_SETTLE = 5'h08,
    ST_SWITCH = 5'h10
  } sw_state_t;

  typedef enum logic [2:0] {
    KEY_LOCKED = 3'h1,
    KEY_FIRST  = 3'h2,
    KEY_OPEN   = 3'h4
  } key_state_t;

  // Synchroniser chains and filtered levels for ready and clock-sense pins
  logic [NV-1:0] sync1_r, sync2_r, sync3_r, filt_r, filt_nxt, prev_r;
  logic [clock_switch_pkg::NUM_OSC-1:0] rdy_s, clk_s, clk_edge;

  // A change is accepted only once stages two and three agree
  always_comb begin
    for (int i = 0; i < NV; i++) begin
      filt_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : filt_r[i];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= '0;
      sync2_r <= '0;
      sync3_r <= '0;
      filt_r  <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= {osc_ready, osc_clk_sense};
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      filt_r  <= filt_nxt;
      prev_r  <= filt_r;
    end
  end

  assign clk_s    = filt_r[clock_switch_pkg::NUM_OSC-1:0];
  assign rdy_s    = filt_r[NV-1:clock_switch_pkg::NUM_OSC];
  assign clk_edge = clk_s & ~prev_r[clock_switch_pkg::NUM_OSC-1:0];

  // Unlock key sequencer
  key_state_t key_r, key_nxt;

  always_comb begin
    key_nxt = key_r;
    if (key_wr) begin
      unique case (key_r)
        KEY_LOCKED: key_nxt = (key_wdata == clock_switch_pkg::UNLOCK_KEY_FIRST)
                              ? KEY_FIRST : KEY_LOCKED;
        KEY_FIRST:  key_nxt = (key_wdata == clock_switch_pkg::UNLOCK_KEY_SECOND)
                              ? KEY_OPEN : KEY_LOCKED;
        KEY_OPEN:   key_nxt = KEY_LOCKED;                // Any further key relocks
        default:    key_nxt = KEY_LOCKED;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) key_r <= KEY_LOCKED;
    else      key_r <= key_nxt;
  end

  // Switch sequencer, control fields and fail-safe monitor
  sw_state_t  st_r, st_nxt;
  logic [2:0] cur_r, cur_nxt, new_r, new_nxt;
  logic       req_r, req_nxt, cf_r, cf_nxt, lock_r, lock_nxt, nmi_nxt;
  logic [10:0] cnt_r, cnt_nxt;
  logic [15:0] mon_r, mon_nxt;
  logic [clock_switch_pkg::NUM_OSC-1:0] en_r, en_nxt;
  logic       sw_enabled, fail, new_ready, crystal;
  int         new_idx, cur_idx;

  assign sw_enabled = ~cfg.switch_monitor_enable_fuse;
  assign new_idx    = clock_switch_pkg::src_index(new_r);
  assign cur_idx    = clock_switch_pkg::src_index(cur_r);
  assign crystal    = (cfg.primary_submode_select == clock_switch_pkg::SUBMODE_CRYSTAL) ||
                      (cfg.primary_submode_select == clock_switch_pkg::SUBMODE_HIGH_SPD);
  // Crystal sources wait out the startup timer instead of a ready pin
  assign new_ready  = (new_r == clock_switch_pkg::SRC_PRIMARY && crystal)
                      ? (cnt_r >= clock_switch_pkg::OST_EDGES) : rdy_s[new_idx];
  // Timeout on the running source's edges; frozen in sleep
  assign fail       = sw_enabled && !sleep_mode &&
                      (mon_r >= 16'(clock_switch_pkg::FAIL_CYCLES - 1));

  always_comb begin
    st_nxt   = st_r;
    cur_nxt  = cur_r;
    new_nxt  = new_r;
    req_nxt  = req_r;
    cf_nxt   = cf_r;
    lock_nxt = lock_r | rdy_s[clock_switch_pkg::OSC_PLL];
    cnt_nxt  = cnt_r;
    nmi_nxt  = 1'b0;
    // Monitor restarts on every edge of the running clock and while asleep
    if (sleep_mode || clk_edge[cur_idx] || fail) mon_nxt = '0;
    else                                         mon_nxt = mon_r + 16'h0001;
    // Software write lands only when unlocked; no retargeting mid-switch
    if (ctrl_wr && key_r == KEY_OPEN && st_r == ST_IDLE) begin
      new_nxt = ctrl_wdata.new_source_select;
      req_nxt = ctrl_wdata.switch_request & sw_enabled;
    end
    unique case (st_r)
      ST_IDLE:  if (req_r && sw_enabled) st_nxt = ST_CHECK;
      ST_CHECK: begin
        if (new_r == cur_r) begin
          req_nxt = 1'b0;
          st_nxt  = ST_IDLE;
        end else begin
          lock_nxt = 1'b0;
          cf_nxt   = 1'b0;
          cnt_nxt  = '0;
          st_nxt   = ST_START;
        end
      end
      ST_START: begin
        if (new_ready) begin
          cnt_nxt = '0;
          st_nxt  = ST_SETTLE;
        end else if (clk_edge[new_idx]) begin
          cnt_nxt = cnt_r + 11'h001;
        end
      end
      ST_SETTLE: begin
        if (cnt_r >= clock_switch_pkg::SETTLE_EDGES) st_nxt = ST_SWITCH;
        else if (clk_edge[new_idx]) cnt_nxt = cnt_r + 11'h001;
      end
      ST_SWITCH: begin
        cur_nxt = new_r;
        req_nxt = 1'b0;
        mon_nxt = '0;
        st_nxt  = ST_IDLE;
      end
    endcase
    // Clock failure overrides any switch in flight; set beats clear
    if (fail) begin
      cur_nxt = clock_switch_pkg::SRC_FAST_RC;
      cf_nxt  = 1'b1;
      nmi_nxt = 1'b1;
      req_nxt = 1'b0;
      st_nxt  = ST_IDLE;
    end
    // Disabled: current source tracks the reset fuse, request held low
    if (!sw_enabled) begin
      cur_nxt = cfg.reset_source_fuse;
      req_nxt = 1'b0;
      st_nxt  = ST_IDLE;
    end
    // Old oscillator drops once no longer current, pending or kept on
    en_nxt = clock_switch_pkg::src_mask(cur_nxt, cfg.pll_from_primary) | osc_keep_on;
    if (st_nxt != ST_IDLE) begin
      en_nxt = en_nxt | clock_switch_pkg::src_mask(new_r, cfg.pll_from_primary);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r     <= ST_IDLE;
      cur_r    <= clock_switch_pkg::SRC_FAST_RC;
      new_r    <= clock_switch_pkg::SRC_FAST_RC;
      req_r    <= 1'b0;
      cf_r     <= 1'b0;
      lock_r   <= 1'b0;
      cnt_r    <= '0;
      mon_r    <= '0;
      en_r     <= 5'h01;
      fail_nmi <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cur_r    <= cur_nxt;
      new_r    <= new_nxt;
      req_r    <= req_nxt;
      cf_r     <= cf_nxt;
      lock_r   <= lock_nxt;
      cnt_r    <= cnt_nxt;
      mon_r    <= mon_nxt;
      en_r     <= en_nxt;
      fail_nmi <= nmi_nxt;
    end
  end

  // Read-back and status; the core is never stalled while switching
  always_comb begin
    ctrl_rdata                       = '0;
    ctrl_rdata.current_source_status = cur_r;
    ctrl_rdata.new_source_select     = new_r;
    ctrl_rdata.clock_fail_flag       = cf_r;
    ctrl_rdata.switch_request        = req_r & sw_enabled;
  end

  assign pll_lock_status         = lock_r;
  assign system_clock_net_select = cur_r;
  assign osc_enable              = en_r;
  assign unlocked                = (key_r == KEY_OPEN);
  assign switch_busy             = (st_r != ST_IDLE);

endmodule
`default_nettype wire

// [dv/clock_switch_monitor.sv]
// Port assertions for the clock switch sequencer and fail-safe monitor
`default_nettype none
module clock_switch_monitor (
  // Clock and reset
  input wire logic                          core_clk,
  input wire logic                          srst,
  // Inputs
  input wire clock_switch_pkg::osc_config_t cfg,
  input wire logic                          sleep_mode,
  input wire logic                          key_wr,
  input wire logic [31:0]                   key_wdata,
  input wire logic                          ctrl_wr,
  // Outputs
  input wire clock_switch_pkg::osc_ctrl_t   ctrl_rdata,
  input wire logic                          pll_lock_status,
  input wire logic                          unlocked,
  input wire logic                          switch_busy,
  input wire logic                          fail_nmi
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Switch starts, told apart by whether the sources differ
  sequence valid_start;
    $rose(switch_busy) && ctrl_rdata.new_source_select != ctrl_rdata.current_source_status;
  endsequence
  sequence same_start;
    $rose(switch_busy) && ctrl_rdata.new_source_select == ctrl_rdata.current_source_status;
  endsequence
  a_req_reads_zero:
    assert property (cfg.switch_monitor_enable_fuse |-> !ctrl_rdata.switch_request)
      else $error("request bit set while switching disabled");
  a_cur_follows_fuse:
    assert property (cfg.switch_monitor_enable_fuse |-> ##1
                     ctrl_rdata.current_source_status == cfg.reset_source_fuse)
      else $error("current source differs from reset fuse");
  a_idle_disabled:
    assert property (cfg.switch_monitor_enable_fuse |-> !switch_busy && !fail_nmi)
      else $error("switch or monitor active while disabled");
  a_sleep_quiet:
    assert property (sleep_mode && $past(sleep_mode) |-> !fail_nmi)
      else $error("clock failure reported during sleep");
  a_fail_to_rc:
    assert property (fail_nmi |-> ctrl_rdata.clock_fail_flag && !switch_busy &&
                     ctrl_rdata.current_source_status == clock_switch_pkg::SRC_FAST_RC)
      else $error("failure did not move to fast RC");
  a_nmi_pulse:
    assert property (fail_nmi |=> !fail_nmi) else $error("failure pulse too long");
  // A clock failure may legally cut a switch short, so it ends these attempts
  a_start_clears:
    assert property (disable iff (srst || fail_nmi)
                     valid_start |-> ##[1:2] !ctrl_rdata.clock_fail_flag && !pll_lock_status)
      else $error("switch start left flags set");
  a_settle_wait:
    assert property (disable iff (srst || fail_nmi) valid_start |-> switch_busy [*8])
      else $error("switch ended too soon");
  a_same_abort:
    assert property (same_start |-> ##[1:2] !switch_busy && !ctrl_rdata.switch_request)
      else $error("redundant switch not aborted");
  a_done_copies:
    assert property ($fell(switch_busy) && !fail_nmi |-> !ctrl_rdata.switch_request &&
                     ctrl_rdata.current_source_status == ctrl_rdata.new_source_select)
      else $error("completion did not copy source");
  a_open_keys:
    assert property ($rose(unlocked) |-> $past(key_wr) &&
                     $past(key_wdata) == clock_switch_pkg::UNLOCK_KEY_SECOND)
      else $error("opened without second key");
  a_locked_ignore:
    assert property (!unlocked && ctrl_wr |=> $stable(ctrl_rdata.new_source_select))
      else $error("locked write changed new source");
endmodule
bind clock_switch_failsafe_monitor clock_switch_monitor chk (.core_clk, .srst, .cfg,
  .sleep_mode, .key_wr, .key_wdata, .ctrl_wr, .ctrl_rdata, .pll_lock_status, .unlocked,
  .switch_busy, .fail_nmi);
`default_nettype wire

// [dv/osc_model.sv]
// Behavioural oscillator bank facing the switch sequencer
`default_nettype none
module osc_model (
  // Controls from design and bench
  input  wire logic [4:0] osc_enable,
  input  wire logic [4:0] kill,
  // Status and clocks back to the design
  output var  logic [4:0] osc_ready,
  output var  logic [4:0] osc_clk_sense
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph = 1'b0;
  // Free phase unrelated to core_clk, slow enough for the synchroniser
  always #250 ph = ~ph;
  // Ready one oscillator cycle after enable; a killed one never readies
  initial osc_ready = 5'h00;
  always @(posedge ph) osc_ready <= osc_enable & ~kill;
  // Disabled or killed oscillators stand still low
  always_comb osc_clk_sense = osc_enable & ~kill & {5{ph}};
endmodule
`default_nettype wire

// [dv/clock_switch_failsafe_monitor_bench.sv]
// Self-checking bench for the clock switch sequencer and fail-safe monitor
`default_nettype none
module clock_switch_failsafe_monitor_bench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct { logic [2:0] src; logic [4:0] en; } row_t;
  logic core_clk = 1'b0, srst = 1'b1, sleep_mode, key_wr, ctrl_wr, pll_lock_status;
  logic unlocked, switch_busy, fail_nmi;
  logic [31:0] key_wdata;
  logic [4:0] osc_ready, osc_clk_sense, osc_keep_on, osc_enable, kill;
  logic [2:0] system_clock_net_select;
  clock_switch_pkg::osc_config_t cfg;
  clock_switch_pkg::osc_ctrl_t   ctrl_wdata, ctrl_rdata;
  int fails = 0, n_checks = 0, i;
  // Target source and oscillators left running; PLL legs pass via fast RC
  row_t rows[7] = '{'{clock_switch_pkg::SRC_SECONDARY, 5'h04},
    '{clock_switch_pkg::SRC_SECONDARY, 5'h04}, '{clock_switch_pkg::SRC_LOW_POWER, 5'h08},
    '{clock_switch_pkg::SRC_PRIMARY, 5'h02}, '{clock_switch_pkg::SRC_FAST_RC, 5'h01},
    '{clock_switch_pkg::SRC_PLL, 5'h11}, '{clock_switch_pkg::SRC_FAST_RC, 5'h01}};
  always #50 core_clk = ~core_clk;
  clock_switch_failsafe_monitor uut (.core_clk, .srst, .cfg, .sleep_mode, .key_wr,
    .key_wdata, .ctrl_wr, .ctrl_wdata, .osc_ready, .osc_clk_sense, .osc_keep_on,
    .osc_enable, .ctrl_rdata, .pll_lock_status, .system_clock_net_select, .unlocked,
    .switch_busy, .fail_nmi);
  osc_model osc (.osc_enable, .kill, .osc_ready, .osc_clk_sense);
  task automatic chk(input string what, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_key(input logic [31:0] k);
    @(negedge core_clk);
    key_wr = 1'b1;
    key_wdata = k;
    @(negedge core_clk);
    key_wr = 1'b0;
  endtask
  // Software order: force lock, two keys, source and request, relock
  task automatic req(input logic [2:0] src);
    wr_key(32'h00000000);
    wr_key(clock_switch_pkg::UNLOCK_KEY_FIRST);
    wr_key(clock_switch_pkg::UNLOCK_KEY_SECOND);
    ctrl_wr = 1'b1;
    ctrl_wdata = '0;
    ctrl_wdata.new_source_select = src;
    ctrl_wdata.switch_request = 1'b1;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    wr_key(32'h00000000);
  endtask
  // Bounded wait for the sequencer to fall idle with the request cleared
  task automatic wait_idle();
    for (i = 0; i < 400 && (switch_busy !== 1'b0 || ctrl_rdata.switch_request !== 1'b0); i++)
      @(negedge core_clk);
    if (i == 400) begin
      fails++;
      complete_run();
    end
  endtask
  initial begin
    cfg = '0;
    sleep_mode = 1'b0;
    key_wr = 1'b0;
    ctrl_wr = 1'b0;
    key_wdata = '0;
    ctrl_wdata = '0;
    kill = 5'h00;
    osc_keep_on = 5'h00;
    cycles(10);
    srst = 1'b0;
    cycles(1);
    chk("ctrl_rdata", ctrl_rdata, 16'h0000);
    chk("osc_enable", osc_enable, 5'h01);
    foreach (rows[r]) begin
      req(rows[r].src);
      wait_idle();
      chk("current", ctrl_rdata.current_source_status, rows[r].src);
      chk("osc_enable", osc_enable, rows[r].en);
      chk("select", system_clock_net_select, rows[r].src);
      if (rows[r].src == clock_switch_pkg::SRC_PLL) chk("lock", pll_lock_status, 1'b1);
    end
    $display("table of switches done");
    // Secondary dies while selected: monitor falls back to fast RC
    req(clock_switch_pkg::SRC_SECONDARY);
    wait_idle();
    kill = 5'h04;
    for (i = 0; i < 1500 && fail_nmi !== 1'b1; i++) @(negedge core_clk);
    chk("fail_nmi", fail_nmi, 1'b1);
    chk("current", ctrl_rdata.current_source_status, clock_switch_pkg::SRC_FAST_RC);
    chk("fail flag", ctrl_rdata.clock_fail_flag, 1'b1);
    // A missed failure would stall every later test, so stop here
    if (fail_nmi !== 1'b1) complete_run();
    // Dead clock during sleep must stay unreported
    sleep_mode = 1'b1;
    kill = 5'h05;
    for (i = 0; i < 1200; i++) begin
      @(negedge core_clk);
      chk("sleep nmi", fail_nmi, 1'b0);
    end
    sleep_mode = 1'b0;
    kill = 5'h00;
    req(clock_switch_pkg::SRC_SECONDARY);
    wait_idle();
    chk("fail flag", ctrl_rdata.clock_fail_flag, 1'b0);
    chk("lock", pll_lock_status, 1'b0);
    $display("fail-safe and sleep done");
    // Locked write ignored; any key while open relocks
    ctrl_wr = 1'b1;
    ctrl_wdata.new_source_select = clock_switch_pkg::SRC_LOW_POWER;
    @(negedge core_clk);
    ctrl_wr = 1'b0;
    cycles(2);
    chk("new", ctrl_rdata.new_source_select, clock_switch_pkg::SRC_SECONDARY);
    wr_key(clock_switch_pkg::UNLOCK_KEY_FIRST);
    wr_key(clock_switch_pkg::UNLOCK_KEY_SECOND);
    chk("unlocked", unlocked, 1'b1);
    wr_key(clock_switch_pkg::UNLOCK_KEY_FIRST);
    chk("unlocked", unlocked, 1'b0);
    $display("lock tests done");
    // Crystal primary counts startup edges; model clock is five core cycles
    cfg.primary_submode_select = clock_switch_pkg::SUBMODE_CRYSTAL;
    osc_keep_on = 5'h04;
    req(clock_switch_pkg::SRC_PRIMARY);
    for (i = 0; i < 6000 && switch_busy !== 1'b0; i++) @(negedge core_clk);
    chk("startup wait", i > 5 * int'(clock_switch_pkg::OST_EDGES), 1'b1);
    wait_idle();
    chk("current", ctrl_rdata.current_source_status, clock_switch_pkg::SRC_PRIMARY);
    chk("osc_enable", osc_enable, 5'h06);
    osc_keep_on = 5'h00;
    $display("crystal startup done");
    // Switching disabled by the fuse: reset source reported, request inert
    srst = 1'b1;
    cfg.switch_monitor_enable_fuse = 1'b1;
    cfg.reset_source_fuse = clock_switch_pkg::SRC_LOW_POWER;
    cycles(10);
    srst = 1'b0;
    cycles(2);
    chk("current", ctrl_rdata.current_source_status, clock_switch_pkg::SRC_LOW_POWER);
    req(clock_switch_pkg::SRC_SECONDARY);
    chk("request", ctrl_rdata.switch_request, 1'b0);
    cycles(60);
    chk("current", ctrl_rdata.current_source_status, clock_switch_pkg::SRC_LOW_POWER);
    $display("disabled fuse done");
    complete_run();
  end
endmodule
`default_nettype wire
